// File: hw/sepr_pkg.sv
// Shared constants, types and decode helpers of the serial EEPROM command block
package sepr_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int SEPR_ADDR_BITS = 15;
    localparam int SEPR_ADDR_W = 16;
    localparam int SEPR_PAGE_BITS = 6;
    localparam int SEPR_PAGE_BYTES = 64;

    // ****************************************
    // Command codes, bit 3 is masked off
    // ****************************************
    localparam logic [7:0] SEPR_CMD_MASK = 8'hF7;
    localparam logic [7:0] SEPR_CMD_SET_WL = 8'h06;
    localparam logic [7:0] SEPR_CMD_CLR_WL = 8'h04;
    localparam logic [7:0] SEPR_CMD_STAT_RD = 8'h05;
    localparam logic [7:0] SEPR_CMD_STAT_WR = 8'h01;
    localparam logic [7:0] SEPR_CMD_ARR_RD = 8'h03;
    localparam logic [7:0] SEPR_CMD_ARR_WR = 8'h02;

    // ****************************************
    // Status byte layout and reset values
    // ****************************************
    localparam int SEPR_ST_BUSY = 0;
    localparam int SEPR_ST_WEL = 1;
    localparam int SEPR_ST_PL_LO = 2;
    localparam int SEPR_ST_PL_HI = 3;
    localparam int SEPR_ST_PPE = 7;
    localparam logic [7:0] SEPR_ST_BUSY_VAL = 8'hFF;
    localparam logic [1:0] SEPR_PL_RST = 2'h0;
    localparam logic SEPR_PPE_RST = 1'b0;
    localparam logic SEPR_WEL_RST = 1'b0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SEPR_CLK_MHZ = 250;
    localparam int SEPR_T_WC_MS = 5;
    localparam int SEPR_WC_CYCLES = SEPR_T_WC_MS * 1000 * SEPR_CLK_MHZ;

    // ****************************************
    // Link phases, Gray along the usual path
    // ****************************************
    typedef enum logic [2:0] {
        SEPR_PH_CMD = 3'h0,
        SEPR_PH_ADDR_HI = 3'h1,
        SEPR_PH_ADDR_LO = 3'h3,
        SEPR_PH_RD_OUT = 3'h2,
        SEPR_PH_WR_IN = 3'h6,
        SEPR_PH_STAT_OUT = 3'h7,
        SEPR_PH_STAT_IN = 3'h5,
        SEPR_PH_IGNORE = 3'h4
    } sepr_phase_t;

    function automatic logic sepr_cmd_is(input logic [7:0] code, input logic [7:0] ref_code);
        return (code & SEPR_CMD_MASK) == ref_code;
    endfunction : sepr_cmd_is

    // Level 1 top quarter, level 2 top half, level 3 whole array
    function automatic logic sepr_prot_hit(input logic [1:0] level, input logic [1:0] top2);
        unique case (level)
            2'h0: return 1'b0;
            2'h1: return top2 == 2'h3;
            2'h2: return top2[1];
            2'h3: return 1'b1;
        endcase
    endfunction : sepr_prot_hit

endpackage : sepr_pkg

// File: hw/sepr_ctl_if.sv
// Carrier between the link-side logic and the nonvolatile control
`timescale 1ns/1ps
interface sepr_ctl_if;
    logic cs_n;
    logic wp_n;
    logic set_tog;
    logic clr_tog;
    logic arr_armed;
    logic st_armed;
    logic [7:0] st_data;
    logic [15:0] wr_addr;
    logic [7:0] status;
    logic busy;
    logic wel;
    logic [1:0] level;
    logic ppe;
    logic arr_go;

    modport link (
        output cs_n, wp_n, set_tog, clr_tog, arr_armed, st_armed, st_data, wr_addr,
        input status, busy, wel, level, ppe, arr_go
    );
    modport ctrl (
        input cs_n, wp_n, set_tog, clr_tog, arr_armed, st_armed, st_data, wr_addr,
        output status, busy, wel, level, ppe, arr_go
    );
endinterface : sepr_ctl_if

// File: hw/sepr_nvctl.sv
// Nonvolatile status bits, write latch, protection checks and write-cycle timer
`timescale 1ns/1ps
module sepr_nvctl
    import sepr_pkg::*;
#(
    parameter int ADDR_BITS = sepr_pkg::SEPR_ADDR_BITS,
    parameter int WC_CYCLES = sepr_pkg::SEPR_WC_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Link-side carrier
    sepr_ctl_if.ctrl ctl
);
    import sepr_pkg::*;

    localparam int CW = $clog2(WC_CYCLES + 1);

    // ****************************************
    // Synchronisers
    // ****************************************
    logic [5:0] s1_ff;
    logic [5:0] s2_ff;
    logic cs_prev_ff;
    logic set_prev_ff;
    logic clr_prev_ff;

    always_ff @(posedge sys_clk_i)
    begin
        s1_ff <= {ctl.cs_n, ctl.wp_n, ctl.set_tog, ctl.clr_tog, ctl.arr_armed, ctl.st_armed};
        s2_ff <= s1_ff;
    end

    // Toggle edge detectors track the synced levels through reset; the select detector is held high
    always_ff @(posedge sys_clk_i)
    begin
        cs_prev_ff <= rst_i ? 1'b1 : s2_ff[5];
        set_prev_ff <= s2_ff[3];
        clr_prev_ff <= s2_ff[2];
    end

    logic cs_rise;
    logic set_ev;
    logic clr_ev;
    logic hw_prot;
    logic arr_ok;
    logic st_ok;
    logic wc_done;
    logic [CW-1:0] wc_cnt_ff;

    assign cs_rise = s2_ff[5] & ~cs_prev_ff;
    assign set_ev = (s2_ff[3] ^ set_prev_ff) & ~rst_i;
    assign clr_ev = (s2_ff[2] ^ clr_prev_ff) & ~rst_i;
    assign hw_prot = ~s2_ff[4] & ctl.ppe;
    assign arr_ok = cs_rise & s2_ff[1] & ctl.wel & ~ctl.busy
        & ~sepr_prot_hit(ctl.level, ctl.wr_addr[ADDR_BITS-1 -: 2]);
    assign st_ok = cs_rise & s2_ff[0] & ctl.wel & ~ctl.busy & ~hw_prot;
    assign wc_done = ctl.busy & (wc_cnt_ff == CW'(1));

    // ****************************************
    // Write cycle timer
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctl.busy <= 1'b0;
            wc_cnt_ff <= '0;
        end
        else if (arr_ok | st_ok)
        begin
            ctl.busy <= 1'b1;
            wc_cnt_ff <= CW'(WC_CYCLES);
        end
        else if (ctl.busy)
        begin
            ctl.busy <= ~wc_done;
            wc_cnt_ff <= wc_cnt_ff - CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        ctl.arr_go <= ~rst_i & arr_ok;
    end

    // ****************************************
    // Write latch, set wins over clear
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            ctl.wel <= SEPR_WEL_RST;
        else if (set_ev)
            ctl.wel <= 1'b1;
        else if (clr_ev | wc_done)
            ctl.wel <= 1'b0;
    end

    // ****************************************
    // Nonvolatile protect bits
    // ****************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctl.level <= SEPR_PL_RST;
            ctl.ppe <= SEPR_PPE_RST;
        end
        else if (st_ok)
        begin
            ctl.level <= ctl.st_data[SEPR_ST_PL_HI:SEPR_ST_PL_LO];
            ctl.ppe <= ctl.st_data[SEPR_ST_PPE];
        end
    end

    // Status byte reads all ones during a write cycle
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            ctl.status <= '0;
        else if (ctl.busy)
            ctl.status <= SEPR_ST_BUSY_VAL;
        else
            ctl.status <= {ctl.ppe, 3'h0, ctl.level, ctl.wel, 1'b0};
    end

endmodule : sepr_nvctl

// File: hw/sepr_top.sv
// Serial EEPROM command, protection and array logic behind an SPI mode 0 slave
//
// Contract
// - Two protect bits select none, quarter, half, all
// - Protect bits nonvolatile, changed via timed write
// - Hardware protect active: pin low, enable set
// - Hardware protect blocks status writes; protected blocks refused
// - Pin enable cannot clear while pin low
// - Read: command, address, then data out MSB-first
// - Read address increments, wraps to zero
// - Busy: only status read accepted
// - Write programs only on byte-boundary select rise
// - Status bit 0 shows write cycle busy
// - Page write wraps within 64-byte page
// - Write latch clears when write cycle ends
// - Write without latch ignored until next frame
// - Sixteen-bit address, unused top bits ignored
// - Eight-bit command codes, bit 3 ignored
// - MSB first, frames start at select fall
// - Status layout; all ones while busy
`timescale 1ns/1ps
module sepr_top
    import sepr_pkg::*;
#(
    parameter int ADDR_BITS = sepr_pkg::SEPR_ADDR_BITS,
    parameter int WC_CYCLES = sepr_pkg::SEPR_WC_CYCLES
) (
    // System clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // SPI link
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_n_o,
    // Write protect pin
    input wire logic wp_n_i,
    // Status view
    output logic busy_o,
    output logic write_latch_o,
    output logic [1:0] protect_level_o,
    output logic protect_pin_enable_o
);
    import sepr_pkg::*;

    localparam int DEPTH = 1 << ADDR_BITS;

    sepr_ctl_if ctl ();

    sepr_nvctl #(
        .ADDR_BITS(ADDR_BITS),
        .WC_CYCLES(WC_CYCLES)
    ) u_nvctl (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ctl(ctl)
    );

    assign ctl.cs_n = spi_cs_n_i;
    assign ctl.wp_n = wp_n_i;
    assign busy_o = ctl.busy;
    assign write_latch_o = ctl.wel;
    assign protect_level_o = ctl.level;
    assign protect_pin_enable_o = ctl.ppe;

    // ****************************************
    // Link state; phase, bit count and shift register cleared while deselected
    // ****************************************
    sepr_phase_t phase_ff;
    sepr_phase_t nxt_phase;
    logic [2:0] bitpos_ff;
    logic [6:0] shift_ff;
    logic [7:0] nxt_byte;
    logic byte_done;
    logic is_wr_ff;
    logic frame_first;
    logic [7:0] stat_s1_ff;
    logic [7:0] stat_s2_ff;
    logic busy_s;

    assign nxt_byte = {shift_ff, spi_mosi_i};
    assign byte_done = bitpos_ff == 3'h7;
    assign frame_first = (phase_ff == SEPR_PH_CMD) && (bitpos_ff == 3'h0);
    assign busy_s = stat_s2_ff[SEPR_ST_BUSY];

    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            phase_ff <= SEPR_PH_CMD;
            bitpos_ff <= 3'h0;
            shift_ff <= 7'h00;
        end
        else
        begin
            phase_ff <= nxt_phase;
            bitpos_ff <= bitpos_ff + 3'h1;
            shift_ff <= nxt_byte[6:0];
        end
    end

    // Status byte crosses as a quasi-static level
    always_ff @(posedge spi_sck_i)
    begin
        stat_s1_ff <= ctl.status;
        stat_s2_ff <= stat_s1_ff;
    end

    // ****************************************
    // Command decode
    // ****************************************
    always_comb
    begin
        nxt_phase = phase_ff;
        if (byte_done)
        begin
            unique case (phase_ff)
                SEPR_PH_CMD:
                begin
                    if (busy_s && !sepr_cmd_is(nxt_byte, SEPR_CMD_STAT_RD))
                        nxt_phase = SEPR_PH_IGNORE;
                    else if (sepr_cmd_is(nxt_byte, SEPR_CMD_STAT_RD))
                        nxt_phase = SEPR_PH_STAT_OUT;
                    else if (sepr_cmd_is(nxt_byte, SEPR_CMD_STAT_WR))
                        nxt_phase = SEPR_PH_STAT_IN;
                    else if (sepr_cmd_is(nxt_byte, SEPR_CMD_ARR_RD)
                        || sepr_cmd_is(nxt_byte, SEPR_CMD_ARR_WR))
                        nxt_phase = SEPR_PH_ADDR_HI;
                    else
                        nxt_phase = SEPR_PH_IGNORE;
                end
                SEPR_PH_ADDR_HI: nxt_phase = SEPR_PH_ADDR_LO;
                SEPR_PH_ADDR_LO: nxt_phase = is_wr_ff ? SEPR_PH_WR_IN : SEPR_PH_RD_OUT;
                SEPR_PH_STAT_IN: nxt_phase = SEPR_PH_IGNORE;
                SEPR_PH_RD_OUT, SEPR_PH_WR_IN, SEPR_PH_STAT_OUT, SEPR_PH_IGNORE:
                    nxt_phase = phase_ff;
            endcase
        end
    end

    // Latch commands leave as toggles, status and array writes as armed levels
    logic set_tog_ff;
    logic clr_tog_ff;
    logic arr_armed_ff;
    logic st_armed_ff;

    always_ff @(posedge spi_sck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            set_tog_ff <= 1'b0;
            clr_tog_ff <= 1'b0;
        end
        else if (!spi_cs_n_i && phase_ff == SEPR_PH_CMD && byte_done && !busy_s)
        begin
            if (sepr_cmd_is(nxt_byte, SEPR_CMD_SET_WL))
                set_tog_ff <= ~set_tog_ff;
            if (sepr_cmd_is(nxt_byte, SEPR_CMD_CLR_WL))
                clr_tog_ff <= ~clr_tog_ff;
        end
    end

    // Armed only right after a complete byte, so a mid-byte rise programs nothing
    always_ff @(posedge spi_sck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            arr_armed_ff <= 1'b0;
            st_armed_ff <= 1'b0;
        end
        else if (!spi_cs_n_i)
        begin
            arr_armed_ff <= (phase_ff == SEPR_PH_WR_IN) && byte_done;
            st_armed_ff <= (phase_ff == SEPR_PH_STAT_IN) && byte_done;
        end
    end

    assign ctl.set_tog = set_tog_ff;
    assign ctl.clr_tog = clr_tog_ff;
    assign ctl.arr_armed = arr_armed_ff;
    assign ctl.st_armed = st_armed_ff;

    // ****************************************
    // Address, page buffer and status data
    // ****************************************
    logic [15:0] addr_ff;
    logic [7:0] st_data_ff;
    logic [7:0] pbuf_ff [SEPR_PAGE_BYTES];
    logic [SEPR_PAGE_BYTES-1:0] valid_ff;

    always_ff @(posedge spi_sck_i)
    begin
        if (!spi_cs_n_i && phase_ff == SEPR_PH_CMD && byte_done)
            is_wr_ff <= sepr_cmd_is(nxt_byte, SEPR_CMD_ARR_WR);
    end

    always_ff @(posedge spi_sck_i)
    begin
        if (!spi_cs_n_i && byte_done)
        begin
            unique case (phase_ff)
                SEPR_PH_ADDR_HI: addr_ff[15:8] <= nxt_byte;
                SEPR_PH_ADDR_LO: addr_ff[7:0] <= nxt_byte;
                SEPR_PH_RD_OUT: addr_ff <= addr_ff + 16'h0001;
                SEPR_PH_WR_IN:
                    addr_ff[SEPR_PAGE_BITS-1:0] <=
                        addr_ff[SEPR_PAGE_BITS-1:0] + 6'h01;
                SEPR_PH_CMD, SEPR_PH_STAT_OUT, SEPR_PH_STAT_IN, SEPR_PH_IGNORE:
                    addr_ff <= addr_ff;
            endcase
        end
    end

    always_ff @(posedge spi_sck_i)
    begin
        if (!spi_cs_n_i && phase_ff == SEPR_PH_STAT_IN && byte_done)
            st_data_ff <= nxt_byte;
    end

    // Excess bytes overwrite earlier ones in the same page slot
    always_ff @(posedge spi_sck_i)
    begin
        if (!spi_cs_n_i && frame_first)
            valid_ff <= '0;
        else if (!spi_cs_n_i && phase_ff == SEPR_PH_WR_IN && byte_done)
        begin
            valid_ff[addr_ff[SEPR_PAGE_BITS-1:0]] <= 1'b1;
            pbuf_ff[addr_ff[SEPR_PAGE_BITS-1:0]] <= nxt_byte;
        end
    end

    assign ctl.wr_addr = addr_ff;
    assign ctl.st_data = st_data_ff;

    // ****************************************
    // Array storage
    // ****************************************
    logic [7:0] mem_ff [DEPTH];

    // Page buffer is stable here: select is high and the next frame has not begun
    always_ff @(posedge sys_clk_i)
    begin
        if (ctl.arr_go)
        begin
            for (int i = 0; i < SEPR_PAGE_BYTES; i++)
            begin
                if (valid_ff[i])
                    mem_ff[{addr_ff[ADDR_BITS-1:SEPR_PAGE_BITS],
                        i[SEPR_PAGE_BITS-1:0]}] <= pbuf_ff[i];
            end
        end
    end

    // ****************************************
    // Serial output on falling edges
    // ****************************************
    logic [7:0] out_ff;
    logic oe_n_ff;
    logic [7:0] src_byte;
    logic out_phase;

    assign out_phase = (phase_ff == SEPR_PH_RD_OUT) || (phase_ff == SEPR_PH_STAT_OUT);
    // Array reads never overlap a write cycle, since every command but status read is refused while busy
    assign src_byte = (phase_ff == SEPR_PH_RD_OUT) ?
        mem_ff[addr_ff[ADDR_BITS-1:0]] : stat_s2_ff;

    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i)
    begin
        if (spi_cs_n_i)
        begin
            out_ff <= 8'h00;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            oe_n_ff <= ~out_phase;
            if (out_phase && bitpos_ff == 3'h0)
                out_ff <= src_byte;
            else
                out_ff <= {out_ff[6:0], 1'b0};
        end
    end

    assign spi_miso_o = out_ff[7];
    assign spi_miso_oe_n_o = oe_n_ff;

endmodule : sepr_top

// File: bench/sepr_top_sva.sv
// Port-level checks of the serial EEPROM block
`timescale 1ns/1ps
module sepr_top_sva #(
    parameter int WC_CYCLES = 50
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_oe_n_o,
    input wire logic wp_n_i,
    input wire logic busy_o,
    input wire logic write_latch_o,
    input wire logic [1:0] protect_level_o,
    input wire logic protect_pin_enable_o
);
    // ****
    // Checks
    // ****
    int unsigned busy_cnt;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !busy_o)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    a_oe_desel: assert property (spi_cs_n_i [*2] |-> spi_miso_oe_n_o)
        else $error("output enabled while deselected");
    a_busy_len: assert property ($fell(busy_o) |->
        busy_cnt >= WC_CYCLES - 1 && busy_cnt <= WC_CYCLES + 1)
        else $error("write cycle length wrong");
    a_busy_max: assert property (busy_cnt <= WC_CYCLES + 1)
        else $error("write cycle too long");
    a_latch_clr_end: assert property ($fell(busy_o) |-> !write_latch_o)
        else $error("latch kept after cycle");
    a_busy_needs_latch: assert property ($rose(busy_o) |-> $past(write_latch_o))
        else $error("cycle without latch");
    a_busy_cs_rise: assert property ($rose(busy_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("cycle started inside frame");
    a_prot_busy_stable: assert property (busy_o && $past(busy_o) |->
        $stable(protect_level_o) && $stable(protect_pin_enable_o))
        else $error("protect bits moved while busy");
    a_prot_need_cycle: assert property ($changed({protect_pin_enable_o, protect_level_o}) |->
        busy_o && $past(write_latch_o))
        else $error("protect bits changed without cycle");
    a_ppe_wp_hold: assert property ((!wp_n_i) [*6] |=> !$fell(protect_pin_enable_o))
        else $error("pin enable cleared while pin low");
    c_write: cover property ($rose(busy_o));
    c_ppe: cover property ($rose(protect_pin_enable_o));
    c_all: cover property (protect_level_o == 2'h3);
endmodule : sepr_top_sva

// File: bench/sepr_spi_master.sv
// SPI mode 0 master model on the far side of the link
`timescale 1ns/1ps
module sepr_spi_master (
    // SPI link
    output logic sck_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_n_i
);
    // ****
    // Frame engine, clock stands low between frames
    // ****
    logic [7:0] rx_q [$];
    logic [7:0] sh = 8'h00;
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx [$], input int extra);
        int nb;
        nb = tx.size() * 8 + extra;
        rx_q.delete();
        cs_n_o = 1'b0;
        #24;
        for (int i = 0; i < nb; i++)
        begin
            mosi_o = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : 1'b1;
            #24;
            sck_o = 1'b1;
            sh = {sh[6:0], miso_oe_n_i ? ~sh[0] : miso_i};
            if (i % 8 == 7)
                rx_q.push_back(sh);
            #24;
            sck_o = 1'b0;
        end
        #24;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #120;
    endtask : xfer
endmodule : sepr_spi_master

// File: bench/sepr_top_tb.sv
// Self-checking testbench of the serial EEPROM block
`timescale 1ns/1ps
module sepr_top_tb;
    import sepr_pkg::*;
    // ****
    // Harness
    // ****
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_n_i = 1'b1;
    wire logic sck, cs_n, mosi, miso, oe_n, busy, wl, ppe;
    wire logic [1:0] lvl;
    int n_fail = 0;
    int cmp_count = 0;
    logic [15:0] prot_lo [1:3] = '{16'h6000, 16'h4000, 16'h0000};
    sepr_top #(.ADDR_BITS(15), .WC_CYCLES(1000)) sepr_top_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .wp_n_i(wp_n_i),
        .busy_o(busy), .write_latch_o(wl), .protect_level_o(lvl),
        .protect_pin_enable_o(ppe));
    sepr_spi_master sepr_spi_master_inst (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso), .miso_oe_n_i(oe_n));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    task automatic end_of_test;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic xf(input logic [7:0] tx [$], input int extra = 0);
        sepr_spi_master_inst.xfer(tx, extra);
        repeat (8) @(posedge sys_clk_i);
    endtask : xf
    task automatic idle;
        for (int i = 0; i < 1500 && busy !== 1'b0; i++)
            @(posedge sys_clk_i);
        chk({7'h0, busy}, 8'h00, "busy end");
    endtask : idle
    task automatic wr(input logic [15:0] a, input logic [7:0] d [$]);
        xf({SEPR_CMD_SET_WL});
        xf({SEPR_CMD_ARR_WR, a[15:8], a[7:0], d});
    endtask : wr
    task automatic stw(input logic [7:0] v);
        xf({SEPR_CMD_SET_WL});
        xf({SEPR_CMD_STAT_WR, v});
    endtask : stw
    task automatic st(input logic [7:0] e);
        xf({SEPR_CMD_STAT_RD, 8'h00});
        chk(sepr_spi_master_inst.rx_q[1], e, "status");
    endtask : st
    task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
        xf({SEPR_CMD_ARR_RD, a[15:8], a[7:0], 8'h00, 8'h00});
        chk(sepr_spi_master_inst.rx_q[3], e0, "read first");
        chk(sepr_spi_master_inst.rx_q[4], e1, "read next");
    endtask : rd
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        chk({ppe, 3'h0, lvl, wl, busy}, 8'h00, "reset view");
        st(8'h00);
        xf({SEPR_CMD_SET_WL});
        chk({7'h0, wl}, 8'h01, "latch set");
        st(8'h02);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_page;
        wr(16'h807E, {8'hA1, 8'hB2, 8'hC3, 8'hD4});
        chk({7'h0, busy}, 8'h01, "busy after write");
        st(8'hFF);
        xf({SEPR_CMD_CLR_WL});
        chk({7'h0, wl}, 8'h01, "command while busy");
        idle();
        chk({7'h0, wl}, 8'h00, "latch after cycle");
        rd(16'h007E, 8'hA1, 8'hB2);
        rd(16'h8040, 8'hC3, 8'hD4);
        wr(16'h7FFF, {8'h5A});
        idle();
        wr(16'h0000, {8'h3C});
        idle();
        rd(16'h7FFF, 8'h5A, 8'h3C);
        $display("t_page done");
    endtask : t_page
    task automatic t_refuse;
        xf({8'h0A, 8'h00, 8'h40, 8'h11});
        chk({7'h0, busy}, 8'h00, "write without latch");
        xf({8'h0E});
        chk({7'h0, wl}, 8'h01, "latch by alt code");
        xf({SEPR_CMD_ARR_WR, 8'h00, 8'h40, 8'h11}, 3);
        chk({7'h0, busy}, 8'h00, "partial byte");
        xf({8'h0C});
        chk({7'h0, wl}, 8'h00, "clear by alt code");
        rd(16'h0040, 8'hC3, 8'hD4);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_levels;
        for (int l = 1; l <= 3; l++)
        begin
            stw(8'(l << 2));
            idle();
            chk({6'h0, lvl}, 8'(l), "level");
            chk({7'h0, wl}, 8'h00, "latch after status write");
            wr(prot_lo[l], {8'h55});
            chk({7'h0, busy}, 8'h00, "protected write");
            if (l < 3)
            begin
                wr(prot_lo[l] - 16'h0001, {8'h55});
                chk({7'h0, busy}, 8'h01, "open write");
                idle();
            end
        end
        stw(8'h00);
        idle();
        $display("t_levels done");
    endtask : t_levels
    task automatic t_hw;
        stw(8'h80);
        idle();
        chk({7'h0, ppe}, 8'h01, "pin enable set");
        wp_n_i <= 1'b0;
        stw(8'h00);
        chk({6'h0, ppe, busy}, 8'h02, "status write blocked");
        wr(16'h0100, {8'h77});
        chk({7'h0, busy}, 8'h01, "array write open");
        idle();
        wp_n_i <= 1'b1;
        stw(8'h00);
        idle();
        chk({7'h0, ppe}, 8'h00, "pin enable cleared");
        st(8'h00);
        $display("t_hw done");
    endtask : t_hw
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        t_reset();
        t_page();
        t_refuse();
        t_levels();
        t_hw();
        end_of_test();
    end
    initial
    begin
        #300_000;
        n_fail++;
        end_of_test();
    end
endmodule : sepr_top_tb
bind sepr_top sepr_top_sva #(.WC_CYCLES(WC_CYCLES)) sepr_top_sva_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_miso_oe_n_o(spi_miso_oe_n_o), .wp_n_i(wp_n_i), .busy_o(busy_o),
    .write_latch_o(write_latch_o), .protect_level_o(protect_level_o),
    .protect_pin_enable_o(protect_pin_enable_o));
